// [bench/amel_flow_model.sv]
// flow-controller stand-in: answers a sync request pulse with a completion level
`timescale 1ns/10ps
module amel_flow_model #(
  parameter int DELAY = 6, // completion rises DELAY+1 cycles after the request is taken
  parameter int HOLD  = 4  // cycles the completion level stands
) (
  input  wire logic clk,   // core clock
  input  wire logic rst_n, // reset, active low
  input  wire logic req,   // one-cycle request pulse
  output logic      done   // completion level
);
  int cnt;

  // request data never reaches here, only the pulse
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= 0;
      done <= 1'b0;
    end else begin
      if (req) begin
        cnt <= DELAY + HOLD;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
      // level drops between completions so each one is a fresh rise
      done <= (cnt != 0) && (cnt <= HOLD);
    end
  end
endmodule

// [bench/amel_tb_top.sv]
// self-checking bench for the attention and multi-sync event logic
`timescale 1ns/10ps
module amel_tb_top;
  logic        MCLK;
  logic        RST_N;
  logic [7:0]  ADDR;
  logic [31:0] WDATA;
  logic        WR;
  logic        RD;
  logic        MSYNC_DONE;
  logic [31:0] RDATA;
  logic        IRQ;
  logic        MSYNC_REQ;
  int          bad_count;
  int          n_checks;
  int          cyc;
  int          req_seen;
  logic [31:0] v;
  logic [31:0] saved;

  amel_top uut (
    .MCLK       (MCLK),
    .RST_N      (RST_N),
    .ADDR       (ADDR),
    .WDATA      (WDATA),
    .WR         (WR),
    .RD         (RD),
    .MSYNC_DONE (MSYNC_DONE),
    .RDATA      (RDATA),
    .IRQ        (IRQ),
    .MSYNC_REQ  (MSYNC_REQ)
  );

  amel_flow_model #(.DELAY(3), .HOLD(4)) flow (
    .clk   (MCLK),
    .rst_n (RST_N),
    .req   (MSYNC_REQ),
    .done  (MSYNC_DONE)
  );

  initial begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (MSYNC_REQ === 1'b1) begin
      req_seen <= req_seen + 1;
    end
    if (cyc == 4000) begin
      bad_count = bad_count + 1;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      bad_count = bad_count + 1;
    end
  endtask

  // one-cycle strobes with an idle cycle after, so no signal is set twice per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
    @(posedge MCLK);
  endtask

  task automatic rdv(input logic [7:0] a, output logic [31:0] d);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 d = RDATA;
    @(posedge MCLK);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rdv(a, d);
    chk(d, exp);
  endtask

  task automatic irq_is(input logic e);
    #1 chk({31'h0, IRQ}, {31'h0, e});
    @(posedge MCLK);
  endtask

  // completion takes several cycles through the pin filter, so poll with a bound
  task automatic poll_pend(output logic [31:0] d);
    d = 32'h0;
    for (int i = 0; i < 30 && d[amel_pkg::EV_MS] !== 1'b1; i++) begin
      rdv(amel_pkg::OFF_PEND, d);
    end
  endtask

  initial begin
    {ADDR, WDATA, WR, RD} = '0;
    RST_N     = 1'b0;
    bad_count = 0;
    n_checks  = 0;
    cyc       = 0;
    req_seen  = 0;
    repeat (6) @(posedge MCLK);
    RST_N <= 1'b1;
    repeat (4) @(posedge MCLK);
    rd(amel_pkg::OFF_PEND, 32'h0);
    rd(amel_pkg::OFF_EV_STAT, 32'h0);
    rd(amel_pkg::OFF_STAT_COUNT, 32'h0);
    rd(amel_pkg::OFF_MS_REQ, 32'h1);
    rd(8'h40, 32'h0);
    // masked attention reaches the pending and interrupt status bits, not event status or count
    wr(amel_pkg::OFF_PRIV_CNTL, 32'h1);
    rd(amel_pkg::OFF_PEND, 32'h2);
    rd(amel_pkg::OFF_EV_STAT, 32'h0);
    rd(amel_pkg::OFF_STAT_COUNT, 32'h0);
    wr(amel_pkg::OFF_PEND, 32'h1);
    rd(amel_pkg::OFF_PEND, 32'h0);
    wr(amel_pkg::OFF_INT_MASK, 32'h3);
    wr(amel_pkg::OFF_EV_MASK, 32'h3);
    wr(amel_pkg::OFF_PRIV_CNTL, 32'h1);
    rd(amel_pkg::OFF_STAT_COUNT, 32'h1);
    rd(amel_pkg::OFF_EV_STAT, 32'h2);
    rd(amel_pkg::OFF_STAT_COUNT, 32'h0);
    irq_is(1'b1);
    wr(amel_pkg::OFF_INT_STAT, 32'h3);
    irq_is(1'b0);
    // handler order: save mask, mask, acknowledge, act, restore
    rdv(amel_pkg::OFF_EV_MASK, saved);
    chk(saved, 32'h3);
    wr(amel_pkg::OFF_EV_MASK, 32'h1);
    wr(amel_pkg::OFF_EV_ACK, 32'h2);
    rd(amel_pkg::OFF_PEND, 32'h0);
    wr(amel_pkg::OFF_EV_MASK, saved);
    // event cleared before the request; all-ones data must be ignored
    wr(amel_pkg::OFF_MS_REQ, 32'hFFFFFFFF);
    poll_pend(v);
    chk(v, 32'h1);
    rd(amel_pkg::OFF_MS_REQ, 32'h1);
    rd(amel_pkg::OFF_STAT_COUNT, 32'h1);
    rd(amel_pkg::OFF_EV_STAT, 32'h1);
    irq_is(1'b1);
    // one combined mask and acknowledge covering both events
    wr(amel_pkg::OFF_EV_MASK, 32'h0);
    wr(amel_pkg::OFF_EV_ACK, 32'h3);
    rd(amel_pkg::OFF_PEND, 32'h0);
    // second request with zero data, completing while its event is masked
    wr(amel_pkg::OFF_MS_REQ, 32'h0);
    poll_pend(v);
    chk(v, 32'h1);
    rd(amel_pkg::OFF_STAT_COUNT, 32'h0);
    rd(amel_pkg::OFF_EV_STAT, 32'h0);
    wr(amel_pkg::OFF_EV_ACK, 32'h1);
    rd(amel_pkg::OFF_PEND, 32'h0);
    wr(amel_pkg::OFF_EV_MASK, 32'h3);
    wr(amel_pkg::OFF_INT_STAT, 32'h1);
    irq_is(1'b0);
    // sticky bit stays set but a cleared mask keeps the line low
    wr(amel_pkg::OFF_INT_MASK, 32'h0);
    wr(amel_pkg::OFF_PRIV_CNTL, 32'h1);
    rd(amel_pkg::OFF_INT_STAT, 32'h2);
    irq_is(1'b0);
    wr(amel_pkg::OFF_PEND, 32'h2);
    rd(amel_pkg::OFF_PEND, 32'h2);
    wr(amel_pkg::OFF_PEND, 32'h0);
    rd(amel_pkg::OFF_PEND, 32'h0);
    // a reset in mid-run must clear state that is set at that moment
    wr(amel_pkg::OFF_PRIV_CNTL, 32'h1);
    rd(amel_pkg::OFF_STAT_COUNT, 32'h1);
    RST_N <= 1'b0;
    repeat (3) @(posedge MCLK);
    RST_N <= 1'b1;
    repeat (4) @(posedge MCLK);
    rd(amel_pkg::OFF_PEND, 32'h0);
    rd(amel_pkg::OFF_EV_STAT, 32'h0);
    rd(amel_pkg::OFF_STAT_COUNT, 32'h0);
    rd(amel_pkg::OFF_MS_REQ, 32'h1);
    chk(req_seen, 32'h2);
    summarize();
  end
endmodule

// [hdl/amel_pkg.sv]
// constants and carrier types for the attention and multi-sync event logic
package amel_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned EV_W   = 2;

  // event bit positions, shared by pending, mask, status, acknowledge
  localparam int unsigned EV_MS   = 0;
  localparam int unsigned EV_ATTN = 1;
  localparam int unsigned CNTL_ATTN_BIT = 0;

  // register byte offsets
  localparam logic [7:0] OFF_PRIV_CNTL  = 8'h00;
  localparam logic [7:0] OFF_PEND       = 8'h04;
  localparam logic [7:0] OFF_EV_MASK    = 8'h08;
  localparam logic [7:0] OFF_EV_STAT    = 8'h0C;
  localparam logic [7:0] OFF_STAT_COUNT = 8'h10;
  localparam logic [7:0] OFF_EV_ACK     = 8'h14;
  localparam logic [7:0] OFF_MS_REQ     = 8'h18;
  localparam logic [7:0] OFF_INT_STAT   = 8'h1C;
  localparam logic [7:0] OFF_INT_MASK   = 8'h20;

  // reset values
  localparam logic [1:0] RST_EV       = 2'h0;
  localparam logic       RST_COUNT    = 1'b0;
  localparam logic       RST_MS_COUNT = 1'b1;
  localparam logic [1:0] RST_RST_PIPE = 2'h0;
  localparam logic [2:0] RST_SYNC     = 3'h0;

  typedef struct packed {
    logic attn;
    logic ms;
  } amel_ev_s;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } amel_bus_s;
endpackage

// [hdl/amel_sync.sv]
// three-stage synchroniser with agreement filter for one asynchronous pin
`timescale 1ns/10ps
module amel_sync (
  input  wire logic clk,     // core clock
  input  wire logic rst_n,   // synchronised reset, active low
  input  wire logic din,     // asynchronous pin
  output logic      dout     // filtered level
);
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic       lvl_reg;
  logic       lvl_next;

  // stage 0 feeds only stage 1; the level moves once stages 1 and 2 agree
  always_comb begin
    sync_next = {sync_reg[1:0], din};
    lvl_next  = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : lvl_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_reg <= amel_pkg::RST_SYNC;
      lvl_reg  <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      lvl_reg  <= lvl_next;
    end
  end

  assign dout = lvl_reg;
endmodule

// [hdl/amel_top.sv]
// attention and multisource-sync event logic with register port and interrupt
`timescale 1ns/10ps
module amel_top (
  input  wire logic        MCLK,       // 200 MHz core clock
  input  wire logic        RST_N,      // asynchronous reset, active low
  input  wire logic [7:0]  ADDR,       // register byte address
  input  wire logic [31:0] WDATA,      // write data
  input  wire logic        WR,         // write strobe
  input  wire logic        RD,         // read strobe
  input  wire logic        MSYNC_DONE, // sync completion level from the flow controller
  output logic      [31:0] RDATA,      // read data, cycle after RD
  output logic             IRQ,        // level interrupt
  output logic             MSYNC_REQ   // one-cycle sync request pulse
);
  localparam int unsigned EW = amel_pkg::EV_W;

  logic [1:0] rst_pipe_reg;
  logic       rst_n;

  // reset asserts at once, releases two edges later
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_pipe_reg <= amel_pkg::RST_RST_PIPE;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_reg[1];

  // one driver for the whole carrier, so no field is left to a second assignment
  amel_pkg::amel_bus_s bus;
  assign bus = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

  logic done_lvl;
  amel_sync u_done_sync (
    .clk   (MCLK),
    .rst_n (rst_n),
    .din   (MSYNC_DONE),
    .dout  (done_lvl)
  );

  // state
  logic          attn_cntl_reg;
  logic          attn_cntl_next;
  logic [EW-1:0] pend_reg;
  logic [EW-1:0] pend_next;
  logic [EW-1:0] mask_reg;
  logic [EW-1:0] mask_next;
  logic [EW-1:0] stat_reg;
  logic [EW-1:0] stat_next;
  logic          count_reg;
  logic          count_next;
  logic          ms_count_reg;
  logic          ms_count_next;
  logic          done_prev_reg;
  logic          done_prev_next;
  logic [EW-1:0] int_stat_reg;
  logic [EW-1:0] int_stat_next;
  logic [EW-1:0] int_mask_reg;
  logic [EW-1:0] int_mask_next;
  logic [31:0]   rdata_reg;
  logic [31:0]   rdata_next;
  logic          irq_reg;
  logic          irq_next;
  logic          msreq_reg;
  logic          msreq_next;

  // decoded strobes and event terms
  logic          wr_cntl;
  logic          wr_pend;
  logic          wr_mask;
  logic          wr_ack;
  logic          wr_msreq;
  logic          wr_istat;
  logic          wr_imask;
  logic          rd_stat;
  logic          done_rise;
  logic [EW-1:0] ack_clr;
  logic [EW-1:0] priv_clr;
  logic [EW-1:0] ev;
  amel_pkg::amel_ev_s ev_s;

  always_comb begin
    wr_cntl  = bus.wr && (bus.addr == amel_pkg::OFF_PRIV_CNTL);
    wr_pend  = bus.wr && (bus.addr == amel_pkg::OFF_PEND);
    wr_mask  = bus.wr && (bus.addr == amel_pkg::OFF_EV_MASK);
    wr_ack   = bus.wr && (bus.addr == amel_pkg::OFF_EV_ACK);
    wr_msreq = bus.wr && (bus.addr == amel_pkg::OFF_MS_REQ);
    wr_istat = bus.wr && (bus.addr == amel_pkg::OFF_INT_STAT);
    wr_imask = bus.wr && (bus.addr == amel_pkg::OFF_INT_MASK);
    rd_stat  = bus.rd && (bus.addr == amel_pkg::OFF_EV_STAT);
    done_rise = done_lvl && !done_prev_reg;
  end

  // request channel count: a request empties it, completion fills it
  always_comb begin
    done_prev_next = done_lvl;
    ms_count_next  = ms_count_reg;
    if (done_rise) begin
      ms_count_next = 1'b1;
    end else if (wr_msreq) begin
      ms_count_next = 1'b0;
    end
    msreq_next = wr_msreq;
  end

  // attention request bit and the two event sources
  always_comb begin
    attn_cntl_next = attn_cntl_reg;
    if (wr_cntl) begin
      attn_cntl_next = bus.wdata[amel_pkg::CNTL_ATTN_BIT];
    end
    ev_s.attn = wr_cntl && bus.wdata[amel_pkg::CNTL_ATTN_BIT];
    ev_s.ms   = !ms_count_reg && ms_count_next;
    ev = '0;
    ev[amel_pkg::EV_ATTN] = ev_s.attn;
    ev[amel_pkg::EV_MS]   = ev_s.ms;
  end

  // pending, mask, status and status count; a new event beats a clear
  always_comb begin
    ack_clr   = wr_ack  ? bus.wdata[EW-1:0]  : '0;
    priv_clr  = wr_pend ? ~bus.wdata[EW-1:0] : '0;
    pend_next = (pend_reg & ~ack_clr & ~priv_clr) | ev;
    mask_next = wr_mask ? bus.wdata[EW-1:0] : mask_reg;
    stat_next = (stat_reg & ~ack_clr) | (ev & mask_reg);
    count_next = count_reg;
    if (|(ev & mask_reg)) begin
      count_next = 1'b1;
    end else if (rd_stat) begin
      count_next = 1'b0;
    end
  end

  // interrupt status is write-one-to-clear; a new event wins
  always_comb begin
    int_stat_next = int_stat_reg & ~(wr_istat ? bus.wdata[EW-1:0] : {EW{1'b0}});
    int_stat_next = int_stat_next | ev;
    int_mask_next = wr_imask ? bus.wdata[EW-1:0] : int_mask_reg;
    irq_next      = |(int_stat_next & int_mask_next);
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = '0;
    if (bus.rd) begin
      case (bus.addr)
        amel_pkg::OFF_PRIV_CNTL:  rdata_next[amel_pkg::CNTL_ATTN_BIT] = attn_cntl_reg;
        amel_pkg::OFF_PEND:       rdata_next[EW-1:0] = pend_reg;
        amel_pkg::OFF_EV_MASK:    rdata_next[EW-1:0] = mask_reg;
        amel_pkg::OFF_EV_STAT:    rdata_next[EW-1:0] = stat_reg;
        amel_pkg::OFF_STAT_COUNT: rdata_next[0] = count_reg;
        amel_pkg::OFF_MS_REQ:     rdata_next[0] = ms_count_reg;
        amel_pkg::OFF_INT_STAT:   rdata_next[EW-1:0] = int_stat_reg;
        amel_pkg::OFF_INT_MASK:   rdata_next[EW-1:0] = int_mask_reg;
        default:                  rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      attn_cntl_reg <= 1'b0;
      pend_reg      <= amel_pkg::RST_EV;
      mask_reg      <= amel_pkg::RST_EV;
      stat_reg      <= amel_pkg::RST_EV;
      count_reg     <= amel_pkg::RST_COUNT;
      ms_count_reg  <= amel_pkg::RST_MS_COUNT;
      done_prev_reg <= 1'b0;
      int_stat_reg  <= amel_pkg::RST_EV;
      int_mask_reg  <= amel_pkg::RST_EV;
      rdata_reg     <= '0;
      irq_reg       <= 1'b0;
      msreq_reg     <= 1'b0;
    end else begin
      attn_cntl_reg <= attn_cntl_next;
      pend_reg      <= pend_next;
      mask_reg      <= mask_next;
      stat_reg      <= stat_next;
      count_reg     <= count_next;
      ms_count_reg  <= ms_count_next;
      done_prev_reg <= done_prev_next;
      int_stat_reg  <= int_stat_next;
      int_mask_reg  <= int_mask_next;
      rdata_reg     <= rdata_next;
      irq_reg       <= irq_next;
      msreq_reg     <= msreq_next;
    end
  end

  assign RDATA     = rdata_reg;
  assign IRQ       = irq_reg;
  assign MSYNC_REQ = msreq_reg;

  // checks next to the logic they guard
  attn_raise_a: assert property (
    @(posedge MCLK) disable iff (!rst_n)
    (wr_cntl && bus.wdata[amel_pkg::CNTL_ATTN_BIT]) |=> pend_reg[amel_pkg::EV_ATTN])
    else $error("attention write did not raise pending");

  ms_raise_a: assert property (
    @(posedge MCLK) disable iff (!rst_n)
    (!ms_count_reg ##1 ms_count_reg) |-> pend_reg[amel_pkg::EV_MS])
    else $error("sync completion did not raise pending");

  enabled_status_a: assert property (
    @(posedge MCLK) disable iff (!rst_n)
    (|(ev & mask_reg)) |=> (count_reg && ((stat_reg & $past(ev & mask_reg)) != '0)))
    else $error("enabled event missing status or count");

  masked_quiet_a: assert property (
    @(posedge MCLK) disable iff (!rst_n)
    (ev[amel_pkg::EV_MS] && !mask_reg[amel_pkg::EV_MS] && !stat_reg[amel_pkg::EV_MS])
      |=> !stat_reg[amel_pkg::EV_MS])
    else $error("masked event set its status");

  ack_attn_a: assert property (
    @(posedge MCLK) disable iff (!rst_n)
    (wr_ack && bus.wdata[amel_pkg::EV_ATTN] && !ev[amel_pkg::EV_ATTN])
      |=> !pend_reg[amel_pkg::EV_ATTN])
    else $error("acknowledge left attention pending");

  ack_ms_a: assert property (
    @(posedge MCLK) disable iff (!rst_n)
    (wr_ack && bus.wdata[amel_pkg::EV_MS] && !ev[amel_pkg::EV_MS])
      |=> !pend_reg[amel_pkg::EV_MS])
    else $error("acknowledge left sync pending");

  priv_clear_a: assert property (
    @(posedge MCLK) disable iff (!rst_n)
    (wr_pend && ev == '0) |=> (pend_reg & ~$past(bus.wdata[EW-1:0])) == '0)
    else $error("pending write did not clear zero bits");

  req_data_a: assert property (
    @(posedge MCLK) disable iff (!rst_n)
    (wr_msreq && !done_rise) |=> (!ms_count_reg && MSYNC_REQ))
    else $error("sync request not taken");

  reset_clear_a: assert property (
    @(posedge MCLK)
    !rst_n |=> (pend_reg == '0 && stat_reg == '0 && !count_reg))
    else $error("state not cleared by reset");

  irq_level_a: assert property (
    @(posedge MCLK) disable iff (!rst_n)
    IRQ == (|(int_stat_reg & int_mask_reg)))
    else $error("interrupt level disagrees with status");

  // a full request count must never raise the sync event again
  ms_refuse_a: assert property (
    @(posedge MCLK) disable iff (!rst_n)
    (ms_count_reg && !wr_msreq && !pend_reg[amel_pkg::EV_MS])
      |=> !pend_reg[amel_pkg::EV_MS])
    else $error("full request count raised sync pending");

  attn_quiet_a: assert property (
    @(posedge MCLK) disable iff (!rst_n)
    (!(wr_cntl && bus.wdata[amel_pkg::CNTL_ATTN_BIT]) && !pend_reg[amel_pkg::EV_ATTN])
      |=> !pend_reg[amel_pkg::EV_ATTN])
    else $error("attention pending set without a request");

  attn_masked_a: assert property (
    @(posedge MCLK) disable iff (!rst_n)
    (ev[amel_pkg::EV_ATTN] && !mask_reg[amel_pkg::EV_ATTN] && !stat_reg[amel_pkg::EV_ATTN])
      |=> !stat_reg[amel_pkg::EV_ATTN])
    else $error("masked attention set its status");

  masked_count_a: assert property (
    @(posedge MCLK) disable iff (!rst_n)
    ((ev & mask_reg) == '0 && !count_reg) |=> !count_reg)
    else $error("status count set without an enabled event");

  pend_keep_a: assert property (
    @(posedge MCLK) disable iff (!rst_n)
    wr_pend |=> ((pend_reg & $past(pend_reg & bus.wdata[EW-1:0]))
      == $past(pend_reg & bus.wdata[EW-1:0])))
    else $error("pending write cleared a bit written as one");

  ack_status_a: assert property (
    @(posedge MCLK) disable iff (!rst_n)
    (wr_ack && (ev & mask_reg) == '0) |=> ((stat_reg & $past(bus.wdata[EW-1:0])) == '0))
    else $error("acknowledge left a status bit set");

  req_pulse_a: assert property (
    @(posedge MCLK) disable iff (!rst_n)
    MSYNC_REQ |-> $past(wr_msreq))
    else $error("sync request pulse without a request write");

  // read data stand for one cycle only, so a late sampler sees zero
  rdata_idle_a: assert property (
    @(posedge MCLK) disable iff (!rst_n)
    !bus.rd |=> (RDATA == '0))
    else $error("read data present without a read");

  int_sticky_a: assert property (
    @(posedge MCLK) disable iff (!rst_n)
    !wr_istat |=> ((int_stat_reg & $past(int_stat_reg)) == $past(int_stat_reg)))
    else $error("interrupt status bit lost without a clear");

  int_raise_a: assert property (
    @(posedge MCLK) disable iff (!rst_n)
    (ev != '0) |=> ((int_stat_reg & $past(ev)) == $past(ev)))
    else $error("event did not set its interrupt status");
endmodule
